// ---- afp_cmd.sv ----
// Feature, idle, sleep and pin mode command handler
`default_nettype none
// Contract
// R1: 01H byte-wide data, 81H back to 16-bit
// R2: No 16-bit indicator while byte-wide mode
// R3: 02H/82H write cache; flush before complete
// R4: 03H uses sector count type and mode
// R5: Type 0: 000b IORDY on, 001b off
// R6: PIO flow, MW DMA, UDMA; reject invalid modes
// R7: 05H/85H advanced power management on/off
// R8: 09H/89H extended power operations on/off
// R9: 55H/AAH look-ahead off/on, default off
// R10: 66H/CCH soft reset keeps/restores defaults
// R11: 69H, 96H, 97H accepted, no change
// R12: Idle: busy, idle, unbusy, interrupt
// R13: Idle nonzero count loads 5 ms timer
// R14: Idle zero count uses 3 ticks
// R15: Sleep: busy, sleep, unbusy, interrupt
// R16: Any command or reset wakes sleep
// R17: Inactivity timer enters sleep, 15 ms default
// R18: 8BH with AAH selects write-protect
// R19: 8BH with 55H selects power-down
// R20: Pin starts as write-protect
// R21: Signature mismatch makes command invalid
// R22: Pin mode kept across resets, power
// R23: Unknown feature aborts, settings unchanged
module afp_cmd #(
   parameter int MAX_PIO_MODE = 6, // Highest flow-controlled PIO mode
   parameter int MAX_MWDMA_MODE = 4, // Highest multiword DMA mode
   parameter int MAX_UDMA_MODE = 6, // Highest Ultra DMA mode
   parameter int TICK_CYC = afp_pkg::IDLE_TICK_CYC, // Cycles per 5 ms tick
   parameter int SLEEP_CYC = afp_pkg::SLEEP_DEFAULT_CYC // Inactivity cycles before sleep
) (
   input wire logic ref_clk, // 10 MHz clock
   input wire logic rst, // Synchronous reset, hard
   input wire logic soft_rst, // Software reset pulse
   input wire logic cmd_valid, // Command register written
   input wire logic [7:0] cmd_code, // Command code
   input wire logic [7:0] feature, // Feature register
   input wire logic [7:0] sec_cnt, // Sector count register
   input wire logic [7:0] sec_num, // Sector number register
   input wire logic [7:0] cyl_low, // Cylinder low register
   input wire logic [7:0] cyl_high, // Cylinder high register
   input wire logic [7:0] drv_head, // Drive/head register
   input wire logic host_activity, // Any host access, holds off sleep
   input wire logic data_reg_access, // Host is accessing data register
   input wire logic flush_done, // Cache flush finished
   input wire logic nv_valid, // Stored pin mode programmed
   input wire logic nv_value, // Stored pin mode
   output logic busy, // Busy status
   output logic irq, // Host interrupt pulse
   output logic abort_err, // Abort error on last command
   output logic flush_req, // Request cache flush
   output logic byte_mode, // Byte-wide data lanes
   output logic sixteen_bit_cycle_indicator, // 16-bit cycle, active high
   output logic wcache_en, // Write cache enabled
   output logic [7:0] xfer_mode, // Selected transfer mode value
   output logic apm_en, // Advanced power management
   output logic epo_en, // Extended power operations
   output logic rla_en, // Read look-ahead
   output logic por_defaults_en, // Soft reset restores defaults
   output logic idle_mode, // In idle mode
   output logic sleep_mode, // In sleep mode
   output logic auto_pd_en, // Automatic power-down armed
   output logic [7:0] idle_count, // Timer count in 5 ms ticks
   output logic pin_pd_mode, // Pin mode: 1 power-down, 0 protect
   output logic nv_wr, // Program store strobe
   output logic nv_wr_val // Value to program
);
   afp_pkg::afp_state_t st_r, st_nxt; // Sequencer
   logic [7:0] cmd_r, cmd_nxt, feat_r, feat_nxt, sc_r, sc_nxt; // Latched command
   logic sig_ok_r, sig_ok_nxt; // Pin command signature matched
   logic busy_r, busy_nxt, irq_r, irq_nxt, abrt_r, abrt_nxt, fl_r, fl_nxt;
   logic byte_r, byte_nxt, wc_r, wc_nxt, apm_r, apm_nxt, epo_r, epo_nxt;
   logic rla_r, rla_nxt, por_r, por_nxt, idle_r, idle_nxt, slp_r, slp_nxt;
   logic apd_r, apd_nxt, ind_r, ind_nxt, nvw_r, nvw_nxt, nvv_r, nvv_nxt, pin_r;
   logic [7:0] xm_r, xm_nxt, icnt_r, icnt_nxt;
   logic tick_load, tick_exp, inact_load, inact_exp;
   logic [7:0] ticks_r, ticks_nxt; // Idle ticks left
   logic pin_mode; // From store

   // Transfer mode value check
   function automatic logic xfer_ok(input logic [7:0] v);
      logic [4:0] t;
      logic [2:0] m;
      t = v[7:afp_pkg::XFER_TYPE_LSB];
      m = v[afp_pkg::XFER_TYPE_LSB-1:0];
      case (t)
         afp_pkg::XT_PIO_DEFAULT: xfer_ok = (m == afp_pkg::XM_IORDY_ON) || (m == afp_pkg::XM_IORDY_OFF); // R5
         afp_pkg::XT_PIO_FLOW: xfer_ok = (32'(m) <= MAX_PIO_MODE); // R6
         afp_pkg::XT_MW_DMA: xfer_ok = (32'(m) <= MAX_MWDMA_MODE); // R6
         afp_pkg::XT_UDMA: xfer_ok = (32'(m) <= MAX_UDMA_MODE); // R6
         default: xfer_ok = 1'b0; // Reserved types
      endcase
   endfunction

   // Idle or sleep command decode
   function automatic logic is_idle(input logic [7:0] c);
      is_idle = (c == afp_pkg::CMD_IDLE_A) || (c == afp_pkg::CMD_IDLE_B);
   endfunction

   function automatic logic is_sleep(input logic [7:0] c);
      is_sleep = (c == afp_pkg::CMD_SLEEP_A) || (c == afp_pkg::CMD_SLEEP_B);
   endfunction

   // Sequencer and settings next state
   always_comb begin
      st_nxt = st_r;
      cmd_nxt = cmd_r;
      feat_nxt = feat_r;
      sc_nxt = sc_r;
      sig_ok_nxt = sig_ok_r;
      busy_nxt = busy_r;
      irq_nxt = 1'b0;
      abrt_nxt = abrt_r;
      fl_nxt = fl_r;
      byte_nxt = byte_r;
      wc_nxt = wc_r;
      xm_nxt = xm_r;
      apm_nxt = apm_r;
      epo_nxt = epo_r;
      rla_nxt = rla_r;
      por_nxt = por_r;
      idle_nxt = idle_r;
      slp_nxt = slp_r;
      apd_nxt = apd_r;
      icnt_nxt = icnt_r;
      nvw_nxt = 1'b0;
      nvv_nxt = nvv_r;
      tick_load = 1'b0;
      // Soft reset: wakes, restores defaults unless kept
      if (soft_rst) begin
         slp_nxt = 1'b0; // R16
         if (por_r) begin // R10
            byte_nxt = 1'b0;
            wc_nxt = 1'b0;
            xm_nxt = afp_pkg::RESET_XFER_MODE;
            apm_nxt = 1'b0;
            epo_nxt = 1'b0;
            rla_nxt = 1'b0;
         end
      end
      case (st_r)
         afp_pkg::AFP_IDLE: begin
            if (cmd_valid) begin
               cmd_nxt = cmd_code;
               feat_nxt = feature;
               sc_nxt = sec_cnt;
               sig_ok_nxt = (cyl_high == afp_pkg::SIG_CYL_HIGH) && (cyl_low == afp_pkg::SIG_CYL_LOW) &&
                  (sec_num == afp_pkg::SIG_SEC_NUM) && (sec_cnt == afp_pkg::SIG_SEC_CNT) &&
                  ((drv_head & ~afp_pkg::DRVHEAD_MASK) == 8'h00); // R21
               busy_nxt = 1'b1; // R12 R15
               slp_nxt = 1'b0; // R16
               abrt_nxt = 1'b0;
               st_nxt = afp_pkg::AFP_EXEC;
            end
         end
         afp_pkg::AFP_EXEC: begin
            st_nxt = afp_pkg::AFP_DONE;
            if (is_idle(cmd_r)) begin
               idle_nxt = 1'b1; // R12
               apd_nxt = 1'b1; // R13 R14
               icnt_nxt = (sc_r == 8'h00) ? afp_pkg::DEFAULT_IDLE_COUNT : sc_r; // R13 R14
               tick_load = 1'b1;
            end else if (is_sleep(cmd_r)) begin
               slp_nxt = 1'b1; // R15
               idle_nxt = 1'b0;
            end else if (cmd_r == afp_pkg::CMD_PIN_MODE) begin
               if (sig_ok_r && feat_r == afp_pkg::PIN_SEL_PROTECT) begin
                  nvw_nxt = 1'b1; // R18
                  nvv_nxt = 1'b0;
               end else if (sig_ok_r && feat_r == afp_pkg::PIN_SEL_POWERDOWN) begin
                  nvw_nxt = 1'b1; // R19
                  nvv_nxt = 1'b1;
               end else begin
                  abrt_nxt = 1'b1; // R21
               end
            end else if (cmd_r == afp_pkg::CMD_SET_FEATURES) begin
               case (feat_r)
                  afp_pkg::FEAT_8BIT_ON: byte_nxt = 1'b1; // R1
                  afp_pkg::FEAT_8BIT_OFF: byte_nxt = 1'b0; // R1
                  afp_pkg::FEAT_WC_ON: wc_nxt = 1'b1; // R3
                  afp_pkg::FEAT_WC_OFF: begin
                     wc_nxt = 1'b0; // R3
                     fl_nxt = 1'b1;
                     st_nxt = afp_pkg::AFP_FLUSH;
                  end
                  afp_pkg::FEAT_XFER_MODE: begin
                     if (xfer_ok(sc_r)) begin
                        xm_nxt = sc_r; // R4
                     end else begin
                        abrt_nxt = 1'b1; // R6
                     end
                  end
                  afp_pkg::FEAT_APM_ON: apm_nxt = 1'b1; // R7
                  afp_pkg::FEAT_APM_OFF: apm_nxt = 1'b0; // R7
                  afp_pkg::FEAT_EPO_ON: epo_nxt = 1'b1; // R8
                  afp_pkg::FEAT_EPO_OFF: epo_nxt = 1'b0; // R8
                  afp_pkg::FEAT_RLA_OFF: rla_nxt = 1'b0; // R9
                  afp_pkg::FEAT_RLA_ON: rla_nxt = 1'b1; // R9
                  afp_pkg::FEAT_POR_KEEP: por_nxt = 1'b0; // R10
                  afp_pkg::FEAT_POR_RESTORE: por_nxt = 1'b1; // R10
                  afp_pkg::FEAT_NOP_A, afp_pkg::FEAT_NOP_B, afp_pkg::FEAT_NOP_C: ; // R11
                  default: abrt_nxt = 1'b1; // R23
               endcase
            end else begin
               abrt_nxt = 1'b1; // Unhandled code
            end
         end
         afp_pkg::AFP_FLUSH: begin
            // Completion waits for the flush so no cached data is lost
            if (flush_done) begin
               fl_nxt = 1'b0; // R3
               st_nxt = afp_pkg::AFP_DONE;
            end
         end
         afp_pkg::AFP_DONE: begin
            busy_nxt = 1'b0; // R12 R15
            irq_nxt = 1'b1; // R12 R15
            st_nxt = afp_pkg::AFP_IDLE;
         end
         default: st_nxt = afp_pkg::AFP_IDLE;
      endcase
      // Inactivity timeout puts the device to sleep on its own
      if (inact_exp && st_r == afp_pkg::AFP_IDLE && !cmd_valid) begin
         slp_nxt = 1'b1; // R17
         idle_nxt = 1'b0;
      end
   end

   // Idle tick counter: counts down 5 ms ticks, then holds at zero
   always_comb begin
      ticks_nxt = ticks_r;
      if (tick_load) begin
         ticks_nxt = icnt_nxt;
      end else if (tick_exp && ticks_r != 8'h00) begin
         ticks_nxt = ticks_r - 8'h01;
      end
   end

   // Settings and status registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         st_r <= afp_pkg::AFP_IDLE;
         cmd_r <= 8'h00;
         feat_r <= 8'h00;
         sc_r <= 8'h00;
         sig_ok_r <= 1'b0;
         busy_r <= 1'b0;
         irq_r <= 1'b0;
         abrt_r <= 1'b0;
         fl_r <= 1'b0;
         byte_r <= 1'b0;
         wc_r <= 1'b0;
         xm_r <= afp_pkg::RESET_XFER_MODE;
         apm_r <= 1'b0;
         epo_r <= 1'b0;
         rla_r <= 1'b0; // R9
         por_r <= 1'b1;
         idle_r <= 1'b0;
         slp_r <= 1'b0; // R16
         apd_r <= 1'b0;
         icnt_r <= afp_pkg::DEFAULT_IDLE_COUNT;
         nvw_r <= 1'b0;
         nvv_r <= 1'b0;
         ind_r <= 1'b0;
         ticks_r <= 8'h00;
         pin_r <= 1'b0; // R20
      end else begin
         st_r <= st_nxt;
         cmd_r <= cmd_nxt;
         feat_r <= feat_nxt;
         sc_r <= sc_nxt;
         sig_ok_r <= sig_ok_nxt;
         busy_r <= busy_nxt;
         irq_r <= irq_nxt;
         abrt_r <= abrt_nxt;
         fl_r <= fl_nxt;
         byte_r <= byte_nxt;
         wc_r <= wc_nxt;
         xm_r <= xm_nxt;
         apm_r <= apm_nxt;
         epo_r <= epo_nxt;
         rla_r <= rla_nxt;
         por_r <= por_nxt;
         idle_r <= idle_nxt;
         slp_r <= slp_nxt;
         apd_r <= apd_nxt;
         icnt_r <= icnt_nxt;
         nvw_r <= nvw_nxt;
         nvv_r <= nvv_nxt;
         ind_r <= ind_nxt;
         ticks_r <= ticks_nxt;
         pin_r <= pin_mode; // R22
      end
   end

   // Indicator held low in byte mode
   always_comb begin
      ind_nxt = data_reg_access && !byte_nxt; // R2
   end

   // Tick timer repeats while idle ticks remain
   afp_cyc_timer #(.WIDTH(32)) u_tick (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(tick_load || (tick_exp && ticks_r > 8'h01)),
      .load_val(32'(TICK_CYC)),
      .stop(cmd_valid),
      .running(),
      .expired(tick_exp)
   );

   // Inactivity timer restarts on any host activity
   assign inact_load = host_activity || cmd_valid || (st_r != afp_pkg::AFP_IDLE);
   afp_cyc_timer #(.WIDTH(32)) u_inact (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(inact_load),
      .load_val(32'(SLEEP_CYC)),
      .stop(slp_r),
      .running(),
      .expired(inact_exp)
   );

   // Mode store outlives every reset
   afp_pin_nv u_nv (
      .ref_clk(ref_clk),
      .nv_valid(nv_valid),
      .nv_value(nv_value),
      .wr(nvw_r),
      .wr_val(nvv_r),
      .pd_mode(pin_mode)
   );

   assign busy = busy_r;
   assign irq = irq_r;
   assign abort_err = abrt_r;
   assign flush_req = fl_r;
   assign byte_mode = byte_r;
   assign sixteen_bit_cycle_indicator = ind_r;
   assign wcache_en = wc_r;
   assign xfer_mode = xm_r;
   assign apm_en = apm_r;
   assign epo_en = epo_r;
   assign rla_en = rla_r;
   assign por_defaults_en = por_r;
   assign idle_mode = idle_r;
   assign sleep_mode = slp_r;
   assign auto_pd_en = apd_r;
   assign idle_count = icnt_r;
   assign pin_pd_mode = pin_r;
   assign nv_wr = nvw_r;
   assign nv_wr_val = nvv_r;

   a_byte_no_ind: assert property (@(posedge ref_clk) disable iff (rst)
      byte_r |-> !ind_r) else $error("indicator asserted in byte mode"); // R2
   a_done_irq: assert property (@(posedge ref_clk) disable iff (rst)
      $fell(busy_r) |-> irq_r) else $error("busy fell without interrupt"); // R12
   a_idle_zero: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == afp_pkg::AFP_EXEC && is_idle(cmd_r) && sc_r == 8'h00) |=> icnt_r == 8'h03)
      else $error("idle zero count not 3"); // R14
   a_idle_load: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == afp_pkg::AFP_EXEC && is_idle(cmd_r) && sc_r != 8'h00) |=> icnt_r == $past(sc_r) && apd_r)
      else $error("idle count not loaded"); // R13
   a_sleep_cmd: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == afp_pkg::AFP_EXEC && is_sleep(cmd_r)) |=> slp_r ##1 !busy_r && irq_r)
      else $error("sleep sequence wrong"); // R15
   a_wake: assert property (@(posedge ref_clk) disable iff (rst)
      (cmd_valid && st_r == afp_pkg::AFP_IDLE) |=> !slp_r) else $error("command did not wake"); // R16
   a_flush_hold: assert property (@(posedge ref_clk) disable iff (rst)
      fl_r |-> busy_r) else $error("completed before flush"); // R3
   a_bad_feat: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == afp_pkg::AFP_EXEC && cmd_r == afp_pkg::CMD_SET_FEATURES && feat_r == 8'h00)
      |=> abrt_r && $stable(xm_r) && $stable(wc_r)) else $error("bad feature not aborted"); // R23
   a_pin_sig: assert property (@(posedge ref_clk) disable iff (rst)
      (st_r == afp_pkg::AFP_EXEC && cmd_r == afp_pkg::CMD_PIN_MODE && !sig_ok_r) |=> abrt_r && !nvw_r)
      else $error("bad signature accepted"); // R21
endmodule
`default_nettype wire

// ---- afp_cmd_test.sv ----
// Bench for the feature, idle, sleep and pin mode command handler
`default_nettype none
module afp_cmd_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk, rst, soft_rst, cmd_valid, host_activity, data_reg_access; // Stimulus
   logic [7:0] cmd_code, feature, sec_cnt, sec_num, cyl_low, cyl_high, drv_head; // Task file
   logic flush_req, flush_done, nv_valid, nv_value, nv_wr, nv_wr_val; // Far side
   logic busy, irq, abort_err, byte_mode, ind16, wcache_en, apm_en, epo_en, rla_en, por_en; // Status
   logic idle_mode, sleep_mode, auto_pd_en, pin_pd_mode; // Power state
   logic [7:0] xfer_mode, idle_count; // Mode values
   int fail_count = 0; // Mismatches
   int checked = 0; // Comparisons
   wire logic [7:0] st = {2'h0, byte_mode, wcache_en, apm_en, epo_en, rla_en, por_en}; // Settings
   localparam logic [31:0] SIG = {afp_pkg::SIG_CYL_HIGH, afp_pkg::SIG_CYL_LOW, afp_pkg::SIG_SEC_NUM, 8'h00};
   localparam logic [7:0] EF = afp_pkg::CMD_SET_FEATURES;
   // Feature code then expected settings, applied in order
   logic [15:0] ftab [16] = '{16'h0121, 16'h0231, 16'h0539, 16'h093d, 16'haa3f, 16'h663e, 16'h963e, 16'h811e,
      16'h820e, 16'h8506, 16'h8902, 16'h5500, 16'hcc01, 16'h6901, 16'h9701, 16'h0001};
   // Sector count, expected mode value, expected abort
   logic [16:0] xtab [7] = '{{8'h0a, 8'h0a, 1'b0}, {8'h01, 8'h01, 1'b0}, {8'h00, 8'h00, 1'b0},
      {8'h24, 8'h24, 1'b0}, {8'h46, 8'h46, 1'b0}, {8'hf8, 8'h46, 1'b1}, {8'h47, 8'h46, 1'b1}};
   // Short counts keep the timer scenarios brief
   afp_cmd #(.TICK_CYC(10), .SLEEP_CYC(30)) DUT (.ref_clk(ref_clk), .rst(rst), .soft_rst(soft_rst),
      .cmd_valid(cmd_valid), .cmd_code(cmd_code), .feature(feature), .sec_cnt(sec_cnt), .sec_num(sec_num),
      .cyl_low(cyl_low), .cyl_high(cyl_high), .drv_head(drv_head), .host_activity(host_activity),
      .data_reg_access(data_reg_access), .flush_done(flush_done), .nv_valid(nv_valid), .nv_value(nv_value),
      .busy(busy), .irq(irq), .abort_err(abort_err), .flush_req(flush_req), .byte_mode(byte_mode),
      .sixteen_bit_cycle_indicator(ind16), .wcache_en(wcache_en), .xfer_mode(xfer_mode), .apm_en(apm_en),
      .epo_en(epo_en), .rla_en(rla_en), .por_defaults_en(por_en), .idle_mode(idle_mode),
      .sleep_mode(sleep_mode), .auto_pd_en(auto_pd_en), .idle_count(idle_count),
      .pin_pd_mode(pin_pd_mode), .nv_wr(nv_wr), .nv_wr_val(nv_wr_val));
   afp_far_model far (.ref_clk(ref_clk), .flush_req(flush_req), .flush_done(flush_done), .nv_wr(nv_wr),
      .nv_wr_val(nv_wr_val), .nv_valid(nv_valid), .nv_value(nv_value));
   // Clock at 100 ns period
   initial begin
      ref_clk = 1'b0;
      forever #50 ref_clk = ~ref_clk;
   end
   // Value comparison
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checked++;
      if (got !== exp) begin
         fail_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // One command, held a single edge, then wait for its interrupt
   task automatic cmd(input logic [7:0] c, input logic [7:0] f, input logic [7:0] s, input logic [31:0] r);
      int n;
      n = 0;
      @(posedge ref_clk);
      cmd_code <= c;
      feature <= f;
      sec_cnt <= s;
      {cyl_high, cyl_low, sec_num, drv_head} <= r;
      cmd_valid <= 1'b1;
      @(posedge ref_clk);
      cmd_valid <= 1'b0;
      #1;
      chk({7'h0, busy}, 8'h01);
      while (irq !== 1'b1 && n < 300) begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      chk({6'h0, busy, irq}, 8'h01);
   endtask
   // Reset pulse of the given kind and length
   task automatic pulse(input logic hard, input int len);
      @(posedge ref_clk);
      if (hard) rst <= 1'b1;
      else soft_rst <= 1'b1;
      repeat (len) @(posedge ref_clk);
      rst <= 1'b0;
      soft_rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
   endtask
   // Ends the run with the verdict
   task automatic tally_and_finish;
      if (fail_count == 0 && checked > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   // Watchdog well beyond the expected few hundred cycles
   initial begin
      repeat (20000) @(posedge ref_clk);
      fail_count++;
      tally_and_finish();
   end
   // Main sequence
   initial begin
      {rst, soft_rst, cmd_valid, host_activity, data_reg_access} = 5'b10000;
      {cmd_code, feature, sec_cnt, sec_num, cyl_low, cyl_high, drv_head} = '0;
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      repeat (2) @(posedge ref_clk);
      #1;
      chk(st, 8'h01);
      chk({7'h0, pin_pd_mode}, 8'h00);
      // Every feature code except 03, last one unknown
      foreach (ftab[i]) begin
         cmd(EF, ftab[i][15:8], 8'h00, 32'h0);
         chk(st, ftab[i][7:0]);
         chk({7'h0, abort_err}, {7'h0, i == 15});
      end
      // Transfer mode values, valid and invalid
      foreach (xtab[i]) begin
         cmd(EF, afp_pkg::FEAT_XFER_MODE, xtab[i][16:9], 32'h0);
         chk(xfer_mode, xtab[i][8:1]);
         chk({7'h0, abort_err}, {7'h0, xtab[i][0]});
      end
      // Byte lanes hide the 16-bit indicator
      data_reg_access <= 1'b1;
      cmd(EF, afp_pkg::FEAT_8BIT_ON, 8'h00, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({7'h0, ind16}, 8'h00);
      cmd(EF, afp_pkg::FEAT_8BIT_OFF, 8'h00, 32'h0);
      repeat (2) @(posedge ref_clk);
      #1;
      chk({7'h0, ind16}, 8'h01);
      data_reg_access <= 1'b0;
      // Software reset restores defaults only when allowed
      cmd(EF, afp_pkg::FEAT_8BIT_ON, 8'h00, 32'h0);
      pulse(1'b0, 1);
      chk(st, 8'h01);
      cmd(EF, afp_pkg::FEAT_POR_KEEP, 8'h00, 32'h0);
      cmd(EF, afp_pkg::FEAT_8BIT_ON, 8'h00, 32'h0);
      pulse(1'b0, 1);
      chk(st, 8'h20);
      cmd(EF, afp_pkg::FEAT_POR_RESTORE, 8'h00, 32'h0);
      // Idle with default and explicit timer counts
      cmd(afp_pkg::CMD_IDLE_B, 8'h00, 8'h00, 32'h0);
      chk({idle_mode, auto_pd_en, idle_count[5:0]}, 8'hc3);
      cmd(afp_pkg::CMD_IDLE_A, 8'h00, 8'h05, 32'h0);
      chk({idle_mode, auto_pd_en, idle_count[5:0]}, 8'hc5);
      // Sleep by both codes, woken by later commands
      cmd(afp_pkg::CMD_SLEEP_A, 8'h00, 8'h00, 32'h0);
      chk({7'h0, sleep_mode}, 8'h01);
      cmd(EF, afp_pkg::FEAT_NOP_A, 8'h00, 32'h0);
      chk({7'h0, sleep_mode}, 8'h00);
      cmd(afp_pkg::CMD_SLEEP_B, 8'h00, 8'h00, 32'h0);
      chk({7'h0, sleep_mode}, 8'h01);
      cmd(EF, afp_pkg::FEAT_NOP_B, 8'h00, 32'h0);
      chk({7'h0, sleep_mode}, 8'h00);
      // Inactivity puts the device to sleep on its own
      repeat (45) @(posedge ref_clk);
      #1;
      chk({7'h0, sleep_mode}, 8'h01);
      // Pin mode: select, bad signatures, survive reset, restore
      cmd(afp_pkg::CMD_PIN_MODE, afp_pkg::PIN_SEL_POWERDOWN, afp_pkg::SIG_SEC_CNT, SIG);
      chk({abort_err, pin_pd_mode}, 8'h01);
      cmd(afp_pkg::CMD_PIN_MODE, afp_pkg::PIN_SEL_PROTECT, afp_pkg::SIG_SEC_CNT, SIG | 32'h1);
      chk({abort_err, pin_pd_mode}, 8'h03);
      cmd(afp_pkg::CMD_PIN_MODE, afp_pkg::PIN_SEL_PROTECT, 8'h51, SIG);
      chk({abort_err, pin_pd_mode}, 8'h03);
      pulse(1'b1, 2);
      chk({7'h0, pin_pd_mode}, 8'h01);
      cmd(afp_pkg::CMD_PIN_MODE, afp_pkg::PIN_SEL_PROTECT, afp_pkg::SIG_SEC_CNT, SIG);
      chk({abort_err, pin_pd_mode}, 8'h00);
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ---- afp_cyc_timer.sv ----
// Down counter that pulses once when a loaded cycle count runs out
`default_nettype none
module afp_cyc_timer #(
   parameter int WIDTH = 32
) (
   input wire logic ref_clk, // System clock
   input wire logic rst, // Synchronous reset
   input wire logic load, // Load and start
   input wire logic [WIDTH-1:0] load_val, // Cycles to run
   input wire logic stop, // Halt without expiry
   output logic running, // Counting
   output logic expired // One-cycle pulse at end
);
   logic [WIDTH-1:0] cnt_r, cnt_nxt; // Remaining cycles
   logic run_r, run_nxt; // Active flag
   logic exp_r, exp_nxt; // Expiry pulse

   // Next count; load beats stop beats decrement
   always_comb begin
      cnt_nxt = cnt_r;
      run_nxt = run_r;
      exp_nxt = 1'b0;
      if (load) begin
         cnt_nxt = (load_val == '0) ? WIDTH'(1) : load_val;
         run_nxt = 1'b1;
      end else if (stop) begin
         run_nxt = 1'b0;
      end else if (run_r) begin
         if (cnt_r == WIDTH'(1)) begin
            run_nxt = 1'b0;
            exp_nxt = 1'b1;
         end
         cnt_nxt = cnt_r - WIDTH'(1);
      end
   end

   // Registers
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cnt_r <= '0;
         run_r <= 1'b0;
         exp_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         run_r <= run_nxt;
         exp_r <= exp_nxt;
      end
   end

   assign running = run_r;
   assign expired = exp_r;
endmodule
`default_nettype wire

// ---- afp_far_model.sv ----
// Far-side model: cache flush responder and non-volatile pin mode store
`default_nettype none
module afp_far_model #(
   parameter int FLUSH_LAT = 6 // Cycles a flush takes
) (
   input wire logic ref_clk, // System clock
   input wire logic flush_req, // Flush wanted
   output logic flush_done, // Flush finished
   input wire logic nv_wr, // Program strobe
   input wire logic nv_wr_val, // Value to program
   output logic nv_valid, // Store programmed
   output logic nv_value // Stored mode
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt; // Flush progress
   // Unprogrammed at power-up, so the pin starts in protect mode
   initial begin
      cnt = 0;
      flush_done = 1'b0;
      nv_valid = 1'b0;
      nv_value = 1'b0;
   end
   // Slow flush, so completion is seen to wait for it
   always @(posedge ref_clk) begin
      cnt <= flush_req ? cnt + 1 : 0;
      flush_done <= flush_req && cnt >= FLUSH_LAT;
   end
   // Store ignores every reset; only a program strobe changes it
   always @(posedge ref_clk) begin
      if (nv_wr) begin
         nv_valid <= 1'b1;
         nv_value <= nv_wr_val;
      end
   end
endmodule
`default_nettype wire

// ---- afp_pin_nv.sv ----
// Non-volatile keeper for the shared protect or power-down pin mode
`default_nettype none
module afp_pin_nv (
   input wire logic ref_clk, // System clock
   input wire logic nv_valid, // Stored value is programmed
   input wire logic nv_value, // Stored value, 1 = power-down
   input wire logic wr, // Program request
   input wire logic wr_val, // Value to program
   output logic pd_mode // 1 = power-down, 0 = protect
);
   // No reset: the mode survives every reset; an unprogrammed store reads protect
   logic mode_r, mode_nxt; // Mirror of the stored mode

   // Follow the store each cycle; a program request overrides it
   always_comb begin
      mode_nxt = nv_valid & nv_value;
      if (wr) begin
         mode_nxt = wr_val;
      end
   end

   always_ff @(posedge ref_clk) begin
      mode_r <= mode_nxt;
   end

   // Bypass so a new mode shows in the cycle it is programmed
   assign pd_mode = wr ? wr_val : mode_r;
endmodule
`default_nettype wire

// ---- afp_pkg.sv ----
// Shared constants for the feature and power mode command handler
`default_nettype none
package afp_pkg;
   // Command codes
   localparam logic [7:0] CMD_SET_FEATURES = 8'hef;
   localparam logic [7:0] CMD_IDLE_A = 8'h97;
   localparam logic [7:0] CMD_IDLE_B = 8'he3;
   localparam logic [7:0] CMD_SLEEP_A = 8'h99;
   localparam logic [7:0] CMD_SLEEP_B = 8'he6;
   localparam logic [7:0] CMD_PIN_MODE = 8'h8b;
   // Feature codes
   localparam logic [7:0] FEAT_8BIT_ON = 8'h01;
   localparam logic [7:0] FEAT_8BIT_OFF = 8'h81;
   localparam logic [7:0] FEAT_WC_ON = 8'h02;
   localparam logic [7:0] FEAT_WC_OFF = 8'h82;
   localparam logic [7:0] FEAT_XFER_MODE = 8'h03;
   localparam logic [7:0] FEAT_APM_ON = 8'h05;
   localparam logic [7:0] FEAT_APM_OFF = 8'h85;
   localparam logic [7:0] FEAT_EPO_ON = 8'h09;
   localparam logic [7:0] FEAT_EPO_OFF = 8'h89;
   localparam logic [7:0] FEAT_RLA_OFF = 8'h55;
   localparam logic [7:0] FEAT_RLA_ON = 8'haa;
   localparam logic [7:0] FEAT_POR_KEEP = 8'h66;
   localparam logic [7:0] FEAT_POR_RESTORE = 8'hcc;
   localparam logic [7:0] FEAT_NOP_A = 8'h69;
   localparam logic [7:0] FEAT_NOP_B = 8'h96;
   localparam logic [7:0] FEAT_NOP_C = 8'h97;
   // Pin mode command signature and selectors
   localparam logic [7:0] SIG_CYL_HIGH = 8'h6e;
   localparam logic [7:0] SIG_CYL_LOW = 8'h44;
   localparam logic [7:0] SIG_SEC_NUM = 8'h72;
   localparam logic [7:0] SIG_SEC_CNT = 8'h50;
   localparam logic [7:0] PIN_SEL_PROTECT = 8'haa;
   localparam logic [7:0] PIN_SEL_POWERDOWN = 8'h55;
   localparam logic [7:0] DRVHEAD_MASK = 8'h10;
   // Transfer mode field layout
   localparam int XFER_TYPE_LSB = 3;
   localparam logic [4:0] XT_PIO_DEFAULT = 5'h00;
   localparam logic [4:0] XT_PIO_FLOW = 5'h01;
   localparam logic [4:0] XT_MW_DMA = 5'h04;
   localparam logic [4:0] XT_UDMA = 5'h08;
   localparam logic [2:0] XM_IORDY_ON = 3'h0;
   localparam logic [2:0] XM_IORDY_OFF = 3'h1;
   // Reset values
   localparam logic [7:0] RESET_XFER_MODE = 8'h00;
   localparam logic [7:0] DEFAULT_IDLE_COUNT = 8'h03;
   // Timing
   localparam int CLK_HZ = 10_000_000;
   localparam int IDLE_TICK_MS = 5;
   localparam int IDLE_TICK_CYC = CLK_HZ / 1000 * IDLE_TICK_MS;
   localparam int SLEEP_DEFAULT_MS = 15;
   localparam int SLEEP_DEFAULT_CYC = CLK_HZ / 1000 * SLEEP_DEFAULT_MS;
   // Command sequencer states
   typedef enum logic [2:0] {
      AFP_IDLE = 3'b000,
      AFP_EXEC = 3'b001,
      AFP_FLUSH = 3'b010,
      AFP_DONE = 3'b011
   } afp_state_t;
endpackage
`default_nettype wire
